// *** logic/tixe_cfg.svh ***
`ifndef TIXE_CFG_SVH
`define TIXE_CFG_SVH
// ------------------------------
// Register map (byte addresses)
// ------------------------------
`define TIXE_A_INSTR 8'h00
`define TIXE_A_EXT 8'h04
`define TIXE_A_STAT 8'h08
`define TIXE_A_GLOB 2'b01
`define TIXE_A_LOC 2'b10
// ------------------------------
// Instruction classes, op[15:10]
// ------------------------------
`define TIXE_CLS_TRAP 6'h3f
`define TIXE_CLS_XM 6'h26
`define TIXE_CLS_XOR 6'h0a
`define TIXE_CLS_IMMEDIATE_BITWISE_DIFFERENCE 6'h1e
// ------------------------------
// Status word field positions
// ------------------------------
`define TIXE_SR_C 0
`define TIXE_SR_Z 1
`define TIXE_SR_N 2
`define TIXE_SR_V 3
`define TIXE_SR_M 4
`define TIXE_SR_T 5
`define TIXE_SR_L 15
`define TIXE_SR_S 18
`define TIXE_SR_ILC 20:19
`define TIXE_SR_FL 24:21
`define TIXE_SR_FP 31:25
`define TIXE_SR_RST 32'h0000_0000
// ------------------------------
// Frame, entry and length constants
// ------------------------------
`define TIXE_FL_ZERO 5'h10
`define TIXE_FL_NEW 4'h6
`define TIXE_ENTRY_ONES 24'hff_ffff
`define TIXE_RANGE_TRAPNO 6'h3e
`define TIXE_LEN_ONE 32'h0000_0002
`define TIXE_LEN_TWO 32'h0000_0004
`define TIXE_LEN_THREE 32'h0000_0006
`define TIXE_ILC_ONE 2'h1
`define TIXE_ILC_TWO 2'h2
`define TIXE_ILC_THREE 2'h3
`endif

// *** logic/tixe_pkg.sv ***
package tixe_pkg;
    // One-hot kind of the instruction being executed
    typedef enum logic [4:0] {
        TIXE_K_NONE = 5'h01,
        TIXE_K_TRAP = 5'h02,
        TIXE_K_XM = 5'h04,
        TIXE_K_XOR = 5'h08,
        TIXE_K_IMMEDIATE_BITWISE_DIFFERENCE = 5'h10
    } tixe_kind_t;
endpackage : tixe_pkg

// *** logic/tixe_exec.sv ***
// Behaviour
// [RL1] Code 4 traps if N or Z set; code 5 only if both clear.
// [RL2] Code 6 traps if N set; code 7 traps if N clear.
// [RL3] Code 8 traps if C or Z set; code 9 only if both clear.
// [RL4] Code 10 traps if C set; code 11 traps if C clear.
// [RL5] Code 12 traps if Z set; code 13 traps if Z clear.
// [RL6] Code 14 traps if V set, else falls through.
// [RL7] Taken trap: PC to entry, S set, save PC//S and status word.
// [RL8] FP grows by old FL (zero means 16), FL becomes six, M T cleared, L set.
// [RL9] Trap number picks one of 64 supervisor entries.
// [RL10] Entry address is 24 ones, address byte bits 7..2, two zeros.
// [RL11] Variant code is op 9..8 with byte 1..0; codes 0..3 are no trap.
// [RL12] Index move writes source shifted left by 0 to 3.
// [RL13] Codes 0..3 raise Range Error when source exceeds bound, unsigned.
// [RL14] Codes 4..7 do the shifted move without range check.
// [RL15] Index moves change no flag; operands are unsigned.
// [RL16] PC as source raises Range Error when PC is at or above bound.
// [RL17] Software never names status word or PC as forbidden operands.
// [RL18] Bound is 12-bit zero-extended, or 28-bit across two halfwords.
// [RL19] Bits 14..12 of the extension select the index move variant.
// [RL20] Register XOR writes destination xor source, updates only Z.
// [RL21] Immediate XOR writes destination xor immediate, updates only Z.
// [RL22] Immediate selector is bit 8 with bits 3..0, values 0..31.
// [RL23] Select bit 0 addresses globals, 1 addresses locals.
// [RL24] Range Error enters supervisor like a trap, destination untouched.
//
// Our own choices: the Wishbone register port and the placing of the registers.
`include "tixe_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tixe_exec (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic trap_o,
    output logic range_err_o
);
    // ------------------------------
    // Storage
    // ------------------------------
    logic [31:0] gr_reg [16];
    logic [31:0] lr_reg [16];
    logic [15:0] instr_reg;
    logic [31:0] ext_reg;
    logic [2:0] stat_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic trap_reg;
    logic range_reg;

    // ------------------------------
    // Wishbone decode
    // ------------------------------
    // Ack in the cycle after the request, dropped the cycle after
    wire req = cyc_i & stb_i;
    wire start = req & ~ack_reg;
    wire wr_fire = req & we_i & ack_reg;
    wire [3:0] ridx = adr_i[5:2];
    wire hit_glob = adr_i[7:6] == `TIXE_A_GLOB;
    wire hit_loc = adr_i[7:6] == `TIXE_A_LOC;
    wire [31:0] bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire exec_go = wr_fire & (adr_i == `TIXE_A_INSTR);
    wire ext_wr = wr_fire & (adr_i == `TIXE_A_EXT);

    // ------------------------------
    // Operand fields
    // ------------------------------
    // The instruction is executed straight off the write data
    wire [15:0] op = dat_i[15:0];
    wire [31:0] pc = gr_reg[0];
    wire [31:0] sr = gr_reg[1];
    wire [6:0] fp = sr[`TIXE_SR_FP];
    wire [3:0] fl = sr[`TIXE_SR_FL];
    wire [3:0] rd_code = op[7:4];
    wire [3:0] rs_code = op[3:0];
    wire dsel = op[9];
    wire ssel = op[8];
    // Locals are a window addressed relative to the frame pointer
    wire [3:0] li_d = fp[3:0] + rd_code;
    wire [3:0] li_s = fp[3:0] + rs_code;
    wire [31:0] src = ssel ? lr_reg[li_s] : gr_reg[rs_code]; // see [RL23]
    wire [31:0] dst = dsel ? lr_reg[li_d] : gr_reg[rd_code]; // see [RL23]
    wire src_is_pc = ~ssel & (rs_code == 4'h0);

    // ------------------------------
    // Instruction kind
    // ------------------------------
    wire [5:0] cls = op[15:10];
    // Codes 0..3 belong to the branch encoding, never a trap
    wire trap_ok = (cls == `TIXE_CLS_TRAP) & (op[9:8] != 2'h0); // see [RL11]
    tixe_pkg::tixe_kind_t kind;
    assign kind = trap_ok ? tixe_pkg::TIXE_K_TRAP :
                  (cls == `TIXE_CLS_XM) ? tixe_pkg::TIXE_K_XM :
                  (cls == `TIXE_CLS_XOR) ? tixe_pkg::TIXE_K_XOR :
                  (cls == `TIXE_CLS_IMMEDIATE_BITWISE_DIFFERENCE) ? tixe_pkg::TIXE_K_IMMEDIATE_BITWISE_DIFFERENCE :
                  tixe_pkg::TIXE_K_NONE;

    // ------------------------------
    // Trap condition
    // ------------------------------
    wire [3:0] tcode = {op[9:8], op[1:0]}; // see [RL11]
    wire fc = sr[`TIXE_SR_C];
    wire fz = sr[`TIXE_SR_Z];
    wire fn = sr[`TIXE_SR_N];
    wire fv = sr[`TIXE_SR_V];
    logic cond;
    // Flag tests per variant code
    always_comb begin
        cond = 1'b0;
        unique case (tcode)
            4'h4: cond = fn | fz; // see [RL1]
            4'h5: cond = ~fn & ~fz; // see [RL1]
            4'h6: cond = fn; // see [RL2]
            4'h7: cond = ~fn; // see [RL2]
            4'h8: cond = fc | fz; // see [RL3]
            4'h9: cond = ~fc & ~fz; // see [RL3]
            4'ha: cond = fc; // see [RL4]
            4'hb: cond = ~fc; // see [RL4]
            4'hc: cond = fz; // see [RL5]
            4'hd: cond = ~fz; // see [RL5]
            4'he: cond = fv; // see [RL6]
            4'hf: cond = 1'b1; // see [RL7]
            default: cond = 1'b0;
        endcase
    end

    // ------------------------------
    // Index move
    // ------------------------------
    // Second halfword in ext[31:16], third halfword in ext[15:0]
    wire ext_e = ext_reg[31];
    wire [2:0] xcode = ext_reg[30:28]; // see [RL19]
    wire [31:0] lim = ext_e ? {4'h0, ext_reg[27:0]} : {20'h0, ext_reg[27:16]}; // see [RL18]
    // Both compares unsigned; PC as source uses at-or-above
    wire over = src_is_pc ? (src >= lim) : (src > lim); // see [RL13] see [RL16]
    wire is_xm = kind == tixe_pkg::TIXE_K_XM;
    wire range_err = is_xm & ~xcode[2] & over; // see [RL13] see [RL14]
    wire [31:0] xm_res = src << xcode[1:0]; // see [RL12]

    // ------------------------------
    // Exclusive OR
    // ------------------------------
    wire [4:0] imm_n = {op[8], op[3:0]}; // see [RL22]
    wire [31:0] xor_res = dst ^ src; // see [RL20]
    wire [31:0] immediate_bitwise_difference_res = dst ^ {27'h0, imm_n}; // see [RL21]
    wire is_xor = kind == tixe_pkg::TIXE_K_XOR;
    wire is_immediate_bitwise_difference = kind == tixe_pkg::TIXE_K_IMMEDIATE_BITWISE_DIFFERENCE;
    wire [31:0] logic_res = is_immediate_bitwise_difference ? immediate_bitwise_difference_res : xor_res;

    // ------------------------------
    // Supervisor entry
    // ------------------------------
    wire take_trap = (kind == tixe_pkg::TIXE_K_TRAP) & cond;
    wire enter_sup = take_trap | range_err; // see [RL24]
    // Trap number chooses one of 64 entries
    wire [5:0] tno = take_trap ? op[7:2] : `TIXE_RANGE_TRAPNO; // see [RL9]
    wire [31:0] entry = {`TIXE_ENTRY_ONES, tno, 2'b00}; // see [RL10]
    wire [31:0] len = is_xm ? (ext_e ? `TIXE_LEN_THREE : `TIXE_LEN_TWO) : `TIXE_LEN_ONE;
    wire [1:0] instruction_length_code = is_xm ? (ext_e ? `TIXE_ILC_THREE : `TIXE_ILC_TWO) : `TIXE_ILC_ONE;
    wire [31:0] ret_pc = pc + len;
    // Zero frame length stands for a full sixteen-word frame
    wire [4:0] fl_eff = (fl == 4'h0) ? `TIXE_FL_ZERO : {1'b0, fl}; // see [RL8]
    wire [6:0] sv0 = fp + {2'b00, fl_eff};
    wire [3:0] sv1 = sv0[3:0] + 4'h1;
    wire [31:0] save_pc = {ret_pc[31:1], sr[`TIXE_SR_S]}; // see [RL7]
    logic [31:0] save_sr;
    logic [31:0] sr_next;
    // Status word after execution
    always_comb begin
        save_sr = sr;
        save_sr[`TIXE_SR_ILC] = instruction_length_code;
        sr_next = sr;
        if (enter_sup) begin
            sr_next[`TIXE_SR_S] = 1'b1; // see [RL7]
            sr_next[`TIXE_SR_FP] = sv0; // see [RL8]
            sr_next[`TIXE_SR_FL] = `TIXE_FL_NEW; // see [RL8]
            sr_next[`TIXE_SR_M] = 1'b0; // see [RL8]
            sr_next[`TIXE_SR_T] = 1'b0; // see [RL8]
            sr_next[`TIXE_SR_L] = 1'b1; // see [RL8]
        end else if (is_xor | is_immediate_bitwise_difference) begin
            sr_next[`TIXE_SR_Z] = (logic_res == 32'h0); // see [RL20] see [RL21]
        end
    end
    // Index moves touch no flag bit of sr_next, so flags stay put (see [RL15])
    wire [31:0] pc_next = enter_sup ? entry : ret_pc; // see [RL7]
    wire legal = kind != tixe_pkg::TIXE_K_NONE;
    wire wr_dst = (is_xm & ~range_err) | is_xor | is_immediate_bitwise_difference; // see [RL24]
    wire [31:0] dst_val = is_xm ? xm_res : logic_res;

    // ------------------------------
    // Register file
    // ------------------------------
    // Execution writes go last so PC and status word win over a
    // destination that names them; such code is reserved anyway (see [RL17])
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 16; i++) begin
                gr_reg[i] <= 32'h0;
                lr_reg[i] <= 32'h0;
            end
            gr_reg[1] <= `TIXE_SR_RST;
        end else if (ce_i) begin
            if (wr_fire & hit_glob) begin
                gr_reg[ridx] <= (gr_reg[ridx] & ~bmask) | (dat_i & bmask);
            end
            if (wr_fire & hit_loc) begin
                lr_reg[ridx] <= (lr_reg[ridx] & ~bmask) | (dat_i & bmask);
            end
            if (exec_go & legal) begin
                if (wr_dst & dsel) begin
                    lr_reg[li_d] <= dst_val;
                end
                if (wr_dst & ~dsel) begin
                    gr_reg[rd_code] <= dst_val;
                end
                if (enter_sup) begin
                    lr_reg[sv0[3:0]] <= save_pc; // see [RL7]
                    lr_reg[sv1] <= save_sr; // see [RL7]
                end
                gr_reg[0] <= pc_next;
                gr_reg[1] <= sr_next;
            end
        end
    end

    // ------------------------------
    // Control registers and outcome
    // ------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_reg <= 16'h0;
            ext_reg <= 32'h0;
            stat_reg <= 3'h0;
            trap_reg <= 1'b0;
            range_reg <= 1'b0;
        end else if (ce_i) begin
            trap_reg <= exec_go & enter_sup;
            range_reg <= exec_go & range_err;
            if (ext_wr) begin
                ext_reg <= (ext_reg & ~bmask) | (dat_i & bmask);
            end
            if (exec_go) begin
                instr_reg <= op;
                stat_reg <= {~legal, range_err, enter_sup};
            end
        end
    end

    // ------------------------------
    // Bus answer
    // ------------------------------
    // Unmapped addresses read zero and are still acknowledged
    wire [31:0] rd_mux = (adr_i == `TIXE_A_INSTR) ? {16'h0, instr_reg} :
                         (adr_i == `TIXE_A_EXT) ? ext_reg :
                         (adr_i == `TIXE_A_STAT) ? {29'h0, stat_reg} :
                         hit_glob ? gr_reg[ridx] :
                         hit_loc ? lr_reg[ridx] : 32'h0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else if (ce_i) begin
            ack_reg <= start;
            if (start) begin
                dat_reg <= rd_mux;
            end
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
    assign trap_o = trap_reg;
    assign range_err_o = range_reg;
endmodule : tixe_exec
`default_nettype wire

// *** tb/tixe_exec_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module tixe_exec_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic trap_o,
    input wire logic range_err_o
);
    // ------------------------------
    // Port checks, one clock domain
    // ------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
        else $error("ack late");
    a_ack_single: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack held");
    a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack unasked");
    // Read data may only move when a request is taken
    a_data_hold: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
        else $error("dat_o moved");
    a_trap_cause: assert property ($rose(trap_o) |-> $past(ack_o && ce_i && we_i && adr_i[7:2] == 6'h00))
        else $error("trap without execution");
    a_trap_pulse: assert property (trap_o && ce_i |=> !trap_o)
        else $error("trap held");
    a_range_trap: assert property (range_err_o |-> trap_o)
        else $error("range error without entry");
    a_range_pulse: assert property (range_err_o && ce_i |=> !range_err_o)
        else $error("range error held");
    // Reset is checked with the reset itself as cause
    a_reset_quiet: assert property (disable iff (1'b0) rst_i && ce_i |=> !ack_o && !trap_o && dat_o == 32'h0)
        else $error("outputs busy after reset");
endmodule : tixe_exec_chk
`default_nettype wire

// *** tb/tixe_exec_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module tixe_exec_test;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, rv, v;
    logic ack_o, trap_o, range_err_o, tr, re, t;
    int errors = 0, comparisons = 0;
    tixe_exec dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .trap_o, .range_err_o);
    always #25 clk_i = ~clk_i;
    // ------------------------------
    // Bus cycle, compare, verdict
    // ------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        // Hold until ack, bounded so a dead slave cannot hang us
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
        rv = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        // A dead slave ends the run through the verdict
        if (n >= 20) begin
            errors++;
            $display("BAD %0t no ack", $time);
            final_report;
        end
        // Event pulses land one cycle after the ack edge
        @(posedge clk_i);
        tr = trap_o;
        re = range_err_o;
    endtask : bus
    task chk(input logic [31:0] got, input logic [31:0] want, input string m);
        comparisons++;
        if (got !== want) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task see(input logic [7:0] a, input logic [31:0] want, input string m);
        bus(1'b0, a, 32'h0);
        chk(rv, want, m);
    endtask : see
    task ex(input logic [15:0] op);
        bus(1'b1, 8'h00, {16'h0, op});
    endtask : ex
    // Preset flags, source and destination, run, check result and flags
    task alu(input logic [15:0] op, input logic [7:0] da, input logic [31:0] di, input logic [7:0] sa,
        input logic [31:0] si, input logic [3:0] f, input logic [31:0] want, input logic [3:0] fz);
        bus(1'b1, 8'h44, {28'h0, f});
        bus(1'b1, sa, si);
        bus(1'b1, da, di);
        ex(op);
        see(da, want, "alu result");
        bus(1'b0, 8'h44, 32'h0);
        chk({28'h0, rv[3:0]}, {28'h0, fz}, "alu flags");
    endtask : alu
    task final_report;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    // Even codes test the condition, odd codes its inverse; 15 always
    function automatic logic taken(input int c, input logic [3:0] f);
        logic b;
        case (c / 2)
            2: b = f[2] | f[1];
            3: b = f[2];
            4: b = f[0] | f[1];
            5: b = f[0];
            6: b = f[1];
            default: b = f[3];
        endcase
        return c == 15 || (b ^ c[0]);
    endfunction : taken
    // ------------------------------
    // Tests
    // ------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        see(8'h44, 32'h0, "status reset");
        bus(1'b1, 8'h3c, 32'hffff_ffff);
        see(8'h3c, 32'h0, "unmapped");
        ex(16'h0000);
        see(8'h08, 32'h4, "illegal");
        see(8'h40, 32'h0, "illegal pc");
        $display("map done");
        for (int c = 4; c < 16; c++) begin
            for (int f = 0; f < 16; f++) begin
                v = {24'hff_ffff, 6'(c * 4 + f), 2'b00};
                t = taken(c, 4'(f));
                bus(1'b1, 8'h44, 32'(f));
                bus(1'b1, 8'h40, 32'h0000_1000);
                ex({6'h3f, 2'(c >> 2), v[7:2], 2'(c)});
                chk({31'h0, tr}, {31'h0, t}, "trap");
                see(8'h40, t ? v : 32'h0000_1002, "trap pc");
                if (t) begin
                    bus(1'b0, 8'h44, 32'h0);
                    chk(rv & 32'hffe7_ffff, 32'h20c4_8000 | 32'(f), "frame");
                end
            end
        end
        // Old S set, nonzero frame, M and T set
        bus(1'b1, 8'h44, 32'h0a64_0035);
        bus(1'b1, 8'h40, 32'h0000_1000);
        ex(16'hffff);
        see(8'ha0, 32'h0000_1003, "saved pc");
        see(8'ha4, 32'h0a6c_0035, "saved status");
        bus(1'b0, 8'h44, 32'h0);
        chk(rv & 32'hffe7_ffff, 32'h10c4_8005, "new frame");
        $display("traps done");
        for (int x = 0; x < 8; x++) begin
            for (int k = 0; k < 4; k++) begin
                v = k == 3 ? 32'h8000_0000 : 32'h0000_00ff + 32'(k);
                t = x < 4 && k >= 2;
                bus(1'b1, 8'h44, 32'h0000_000f);
                bus(1'b1, 8'h40, 32'h0000_1000);
                bus(1'b1, 8'h50, v);
                bus(1'b1, 8'h54, 32'h5a5a_5a5a);
                bus(1'b1, 8'h04, {1'b0, 3'(x), 12'h100, 16'h0});
                ex(16'h9854);
                chk({31'h0, re}, {31'h0, t}, "range");
                see(8'h54, t ? 32'h5a5a_5a5a : v << (x % 4), "move");
                see(8'h40, t ? 32'hffff_fff8 : 32'h0000_1004, "move pc");
                see(8'h08, {30'h0, t, t}, "move status");
                bus(1'b0, 8'h44, 32'h0);
                chk({28'h0, rv[3:0]}, 32'hf, "move flags");
            end
        end
        // Counter as source against a long bound, at and below it
        for (int k = 0; k < 2; k++) begin
            t = k == 0;
            bus(1'b1, 8'h44, 32'h0);
            bus(1'b1, 8'h40, 32'h0123_4568);
            bus(1'b1, 8'h54, 32'h5a5a_5a5a);
            bus(1'b1, 8'h04, {4'h8, 12'h123, 16'h4568 + 16'(k)});
            ex(16'h9850);
            chk({31'h0, re}, {31'h0, t}, "pc bound");
            see(8'h54, t ? 32'h5a5a_5a5a : 32'h0123_4568, "pc moved");
            see(8'h40, t ? 32'hffff_fff8 : 32'h0123_456e, "long pc");
        end
        $display("moves done");
        alu(16'h2856, 8'h54, 32'h1234_5678, 8'h58, 32'h1234_5678, 4'hd, 32'h0, 4'hf);
        alu(16'h2a36, 8'h8c, 32'h0f0f_00ff, 8'h58, 32'hffff_0000, 4'hf, 32'hf0f0_00ff, 4'hd);
        alu(16'h2953, 8'h54, 32'h3, 8'h8c, 32'h1, 4'h2, 32'h2, 4'h0);
        alu(16'h7951, 8'h54, 32'h11, 8'h58, 32'h0, 4'h0, 32'h0, 4'h2);
        alu(16'h795f, 8'h54, 32'h100, 8'h58, 32'h0, 4'hf, 32'h11f, 4'hd);
        alu(16'h7a3a, 8'h8c, 32'h0, 8'h58, 32'h0, 4'h2, 32'ha, 4'h0);
        $display("xor done");
        // Clock enable low stalls a pending write; it must land afterwards
        fork
            bus(1'b1, 8'h48, 32'h600d_f00d);
            begin
                ce_i <= 1'b0;
                repeat (5) @(posedge clk_i);
                ce_i <= 1'b1;
            end
        join
        see(8'h48, 32'h600d_f00d, "frozen write");
        $display("enable done");
        final_report;
    end
    // Watchdog, well past the roughly 5000 cycles the tests need
    initial begin
        #2_000_000;
        errors++;
        final_report;
    end
endmodule : tixe_exec_test
bind tixe_exec tixe_exec_chk u_chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
    .trap_o, .range_err_o);
`default_nettype wire
